/* File: tb_top.sv */
// self-checking bench for the aperture paging block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [31:0] BASE = 32'h1000_0000;
  localparam logic [31:0] LEG  = 32'h0055_aa00;
  logic sys_clk = 1'b0, rst = 1'b1, pci_mem_en = 1'b1;
  logic io_wr, io_rd, mem_req, out_valid, out_paged, out_reserved;
  logic scan_valid;
  logic [15:0] io_addr;
  logic [7:0] io_wdata, io_rdata, misc_gfx, d;
  logic [7:0] misc_output_reg = 8'h02;
  logic [19:0] mem_addr_in;
  logic [6:0] scan_page = 7'h00;
  logic [31:0] out_addr, scan_addr;
  int miscompares = 0, num_checks = 0;
  always #2 sys_clk = ~sys_clk;
  vap_host host (.sys_clk(sys_clk), .io_wr(io_wr), .io_rd(io_rd),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .mem_req(mem_req), .mem_addr_in(mem_addr_in),
    .legacy_misc_graphics_reg(misc_gfx));
  vap_paging #(.ADDR_W(32)) DUT (.sys_clk(sys_clk), .rst(rst),
    .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .mem_req(mem_req),
    .mem_addr_in(mem_addr_in), .pci_mem_en(pci_mem_en),
    .misc_output_reg(misc_output_reg), .legacy_misc_graphics_reg(misc_gfx),
    .stolen_memory_base_reg(BASE), .legacy_addr(LEG),
    .scan_page(scan_page), .out_valid(out_valid),
    .out_paged(out_paged), .out_reserved(out_reserved),
    .out_addr(out_addr), .scan_addr(scan_addr),
    .scan_valid(scan_valid));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic acc(input logic [19:0] a, input logic v, input logic p,
                     input logic r, input logic [31:0] ad);
    host.mem_cyc(a);
    chk(out_valid, v);
    chk(out_paged, p);
    chk(out_reserved, r);
    chk(out_addr, ad);
    // idle edge before the next request
    @(negedge sys_clk);
  endtask : acc
  task automatic t_regs();
    logic [7:0] idx [3] = '{8'h10, 8'h11, 8'h18};
    foreach (idx[i]) begin
      host.reg_rd(idx[i], d);
      chk(d, 8'h00);
      host.reg_wr(idx[i], 8'h5a ^ idx[i]);
      host.reg_rd(idx[i], d);
      chk(d, 8'h5a ^ idx[i]);
    end
    host.reg_wr(8'h12, 8'h5a);
    host.reg_rd(8'h12, d);
    chk(d, 8'h00);
    host.reg_wr(8'h10, 8'h00);
    host.reg_wr(8'h18, 8'hff);
    acc(20'ha1234, 1'b1, 1'b0, 1'b0, LEG);
    $display("test regs done");
  endtask : t_regs
  task automatic t_paged();
    host.reg_wr(8'h11, 8'hff);
    host.paging_on(8'hf1);
    acc(20'ha1237, 1'b1, 1'b1, 1'b0, BASE + 32'h007f_1234);
    host.reg_wr(8'h11, 8'h00);
    acc(20'hafffe, 1'b1, 1'b1, 1'b0, BASE + 32'h0000_fffc);
    acc(20'hb0000, 1'b0, 1'b0, 1'b0, 32'h0);
    acc(20'hc0000, 1'b0, 1'b0, 1'b0, 32'h0);
    pci_mem_en = 1'b0;
    acc(20'ha0000, 1'b0, 1'b0, 1'b0, 32'h0);
    pci_mem_en = 1'b1;
    misc_output_reg = 8'hfd;
    acc(20'ha0000, 1'b0, 1'b0, 1'b0, 32'h0);
    misc_output_reg = 8'h02;
    $display("test paged done");
  endtask : t_paged
  task automatic t_target();
    for (int t = 1; t < 4; t++) begin
      host.reg_wr(8'h10, 8'(t * 2 + 1));
      acc(20'ha0010, 1'b0, 1'b0, 1'b1, 32'h0);
    end
    host.reg_wr(8'h10, 8'h06);
    acc(20'ha0010, 1'b1, 1'b0, 1'b0, LEG);
    $display("test target done");
  endtask : t_target
  task automatic t_reset();
    host.paging_on(8'h01);
    acc(20'ha0004, 1'b1, 1'b1, 1'b0, BASE + 32'h0000_0004);
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    chk(out_valid, 1'b0);
    chk(scan_valid, 1'b0);
    chk(scan_addr, 32'h0);
    host.reg_rd(8'h10, d);
    chk(d, 8'h00);
    host.reg_rd(8'h11, d);
    chk(d, 8'h00);
    acc(20'ha0004, 1'b1, 1'b0, 1'b0, LEG);
    $display("test reset done");
  endtask : t_reset
  task automatic t_scan();
    for (int p = 0; p < 6; p++) begin
      scan_page = 7'(p);
      @(negedge sys_clk);
      chk(scan_valid, p < 4);
      chk(scan_addr, p < 4 ? BASE + (p << 16) : 32'h0);
    end
    $display("test scan done");
  endtask : t_scan
  task automatic summarize();
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize
  initial begin
    #20000;
    miscompares++;
    summarize();
  end
  initial begin
    repeat (8) @(negedge sys_clk);
    rst = 1'b0;
    t_regs();
    t_paged();
    t_target();
    t_reset();
    t_scan();
    summarize();
  end
endmodule : tb_top
`default_nettype wire

/* File: vap_addr_gen.sv */
// paged address former for the a0000 aperture
`timescale 1ns/1ps
`default_nettype none
module vap_addr_gen #(
  parameter int ADDR_W = 32
) (
  input  wire logic [ADDR_W-1:0] base_addr,
  input  wire logic [6:0]        page,
  input  wire logic [15:0]       low_addr,
  output logic      [ADDR_W-1:0] mem_addr
);
  if (ADDR_W < 23) begin : g_width_chk
    $error("vap_addr_gen: ADDR_W below 23");
  end
  logic [22:0] offset;
  // dword lines only; bytes come from the strobes
  assign offset   = {page, low_addr[15:2], 2'b00};
  assign mem_addr = base_addr + ADDR_W'(offset);
endmodule : vap_addr_gen
`default_nettype wire

/* File: vap_host.sv */
// host model driving indexed i/o and aperture memory cycles
`timescale 1ns/1ps
`default_nettype none
module vap_host (
  input  wire logic        sys_clk,
  output logic             io_wr,
  output logic             io_rd,
  output logic      [15:0] io_addr,
  output logic      [7:0]  io_wdata,
  input  wire logic [7:0]  io_rdata,
  output logic             mem_req,
  output logic      [19:0] mem_addr_in,
  output logic      [7:0]  legacy_misc_graphics_reg
);
  initial begin
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_addr = 16'h0000;
    io_wdata = 8'h00;
    mem_req = 1'b0;
    mem_addr_in = 20'h00000;
    legacy_misc_graphics_reg = 8'h00;
  end
  // entered at a falling edge; one strobe cycle, then bus shows inverse
  task automatic io_cyc(input logic w, input logic [15:0] a,
                        input logic [7:0] d);
    io_wr = w;
    io_rd = ~w;
    io_addr = a;
    io_wdata = d;
    @(negedge sys_clk);
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_addr = ~a;
    io_wdata = ~d;
    // idle edge so the next strobe is never raised in this step
    @(negedge sys_clk);
  endtask : io_cyc
  // paging registers only by indexed i/o
  task automatic reg_wr(input logic [7:0] i, input logic [7:0] d);
    io_cyc(1'b1, vap_pkg::VAP_IO_INDEX_PORT, i);
    io_cyc(1'b1, vap_pkg::VAP_IO_DATA_PORT, d);
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] i, output logic [7:0] d);
    io_cyc(1'b1, vap_pkg::VAP_IO_INDEX_PORT, i);
    io_cyc(1'b0, vap_pkg::VAP_IO_DATA_PORT, 8'h00);
    d = io_rdata;
  endtask : reg_rd
  // map select 01 before enable, packed modes only
  task automatic paging_on(input logic [7:0] ctrl);
    legacy_misc_graphics_reg = 8'h04;
    reg_wr(vap_pkg::VAP_IDX_MAP_CTRL, ctrl);
  endtask : paging_on
  task automatic mem_cyc(input logic [19:0] a);
    mem_req = 1'b1;
    mem_addr_in = a;
    @(negedge sys_clk);
    mem_req = 1'b0;
    mem_addr_in = ~a;
  endtask : mem_cyc
endmodule : vap_host
`default_nettype wire

/* File: vap_paging.sv */
// legacy aperture paging with indexed graphics registers
`timescale 1ns/1ps
`default_nettype none
module vap_paging #(
  parameter int ADDR_W = 32
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              io_wr,
  input  wire logic              io_rd,
  input  wire logic [15:0]       io_addr,
  input  wire logic [7:0]        io_wdata,
  output logic      [7:0]        io_rdata,
  input  wire logic              mem_req,
  input  wire logic [19:0]       mem_addr_in,
  input  wire logic              pci_mem_en,
  input  wire logic [7:0]        misc_output_reg,
  input  wire logic [7:0]        legacy_misc_graphics_reg,
  input  wire logic [ADDR_W-1:0] stolen_memory_base_reg,
  input  wire logic [ADDR_W-1:0] legacy_addr,
  input  wire logic [6:0]        scan_page,
  output logic                   out_valid,
  output logic                   out_paged,
  output logic                   out_reserved,
  output logic      [ADDR_W-1:0] out_addr,
  output logic      [ADDR_W-1:0] scan_addr,
  output logic                   scan_valid
);
  if (ADDR_W < 23) begin : g_width_chk
    $error("vap_paging: ADDR_W below 23");
  end

  logic [7:0] index_r;
  logic [7:0] map_ctrl_r;
  logic [7:0] page_sel_r;
  logic [7:0] scratch_r;
  logic [7:0] io_rdata_r;

  // register file, written only by i/o cycles
  wire hit_index = io_addr == vap_pkg::VAP_IO_INDEX_PORT;
  wire hit_data  = io_addr == vap_pkg::VAP_IO_DATA_PORT;
  wire wr_map    = io_wr && hit_data
                   && index_r == vap_pkg::VAP_IDX_MAP_CTRL;
  wire wr_page   = io_wr && hit_data
                   && index_r == vap_pkg::VAP_IDX_PAGE_SEL;
  wire wr_scr    = io_wr && hit_data
                   && index_r == vap_pkg::VAP_IDX_SCRATCH;

  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = io_rdata_r;
    if (io_rd && hit_index) begin
      rd_mux = index_r;
    end else if (io_rd && hit_data) begin
      unique case (index_r)
        vap_pkg::VAP_IDX_MAP_CTRL: rd_mux = map_ctrl_r;
        vap_pkg::VAP_IDX_PAGE_SEL: rd_mux = page_sel_r;
        vap_pkg::VAP_IDX_SCRATCH:  rd_mux = scratch_r;
        default:                   rd_mux = vap_pkg::VAP_RESET_VALUE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      index_r    <= vap_pkg::VAP_RESET_VALUE;
      map_ctrl_r <= vap_pkg::VAP_RESET_VALUE;
      page_sel_r <= vap_pkg::VAP_RESET_VALUE;
      scratch_r  <= vap_pkg::VAP_RESET_VALUE;
      io_rdata_r <= vap_pkg::VAP_RESET_VALUE;
    end else begin
      if (io_wr && hit_index) index_r <= io_wdata;
      if (wr_map) map_ctrl_r <= io_wdata;  // bits 7:3 kept but unused
      if (wr_page) page_sel_r <= io_wdata;
      if (wr_scr) scratch_r <= io_wdata;
      io_rdata_r <= rd_mux;
    end
  end
  assign io_rdata = io_rdata_r;

  // field decode; upper map bits never reach the address path
  wire       page_en = map_ctrl_r[vap_pkg::VAP_ENABLE_BIT];
  wire [1:0] target  = map_ctrl_r[vap_pkg::VAP_TARGET_LSB +: 2];
  wire [6:0] page    = page_sel_r[vap_pkg::VAP_PAGE_MSB:0];
  wire [1:0] map_sel = legacy_misc_graphics_reg[vap_pkg::VAP_MAP_SEL_LSB +: 2];

  // window gating
  wire [3:0] win_hi  = mem_addr_in[19:16];
  wire in_win_a      = win_hi == vap_pkg::VAP_WIN_A_HI;
  wire in_win_b      = win_hi == vap_pkg::VAP_WIN_B_HI;
  wire gate_ok       = pci_mem_en
                       && misc_output_reg[vap_pkg::VAP_MISC_RAM_BIT];
  wire honoured      = mem_req && (in_win_a || in_win_b)
                       && gate_ok;
  // paging trusts the host to pick map select 01; b window then drops
  wire map_a_only    = map_sel == vap_pkg::VAP_MAP_SEL_A0;
  wire paged_cycle   = honoured && page_en && in_win_a;
  wire b_blocked     = honoured && page_en && in_win_b && map_a_only;
  wire tgt_vga       = target == vap_pkg::VAP_TARGET_VGA;

  logic [ADDR_W-1:0] paged_addr;
  vap_addr_gen #(
    .ADDR_W (ADDR_W)
  ) u_addr (
    .base_addr (stolen_memory_base_reg),
    .page      (page),
    .low_addr  (mem_addr_in[15:0]),
    .mem_addr  (paged_addr)
  );

  // scan-out restricted to the first four pages
  logic [ADDR_W-1:0] scan_base;
  wire scan_ok = scan_page < vap_pkg::VAP_SCAN_PAGES;
  vap_addr_gen #(
    .ADDR_W (ADDR_W)
  ) u_scan (
    .base_addr (stolen_memory_base_reg),
    .page      (scan_page),
    .low_addr  (16'h0000),
    .mem_addr  (scan_base)
  );

  logic              out_valid_r;
  logic              out_paged_r;
  logic              out_reserved_r;
  logic [ADDR_W-1:0] out_addr_r;
  logic [ADDR_W-1:0] scan_addr_r;
  logic              scan_valid_r;

  wire               valid_nxt = honoured && !b_blocked
                                 && !(paged_cycle && !tgt_vga);
  wire [ADDR_W-1:0]  addr_nxt  = paged_cycle ? paged_addr
                                             : legacy_addr;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      out_valid_r    <= 1'b0;
      out_paged_r    <= 1'b0;
      out_reserved_r <= 1'b0;
      out_addr_r     <= '0;
      scan_addr_r    <= '0;
      scan_valid_r   <= 1'b0;
    end else begin
      out_valid_r    <= valid_nxt;
      out_paged_r    <= paged_cycle && tgt_vga;
      out_reserved_r <= paged_cycle && !tgt_vga;
      out_addr_r     <= valid_nxt ? addr_nxt : '0;
      scan_addr_r    <= scan_ok ? scan_base : '0;
      scan_valid_r   <= scan_ok;
    end
  end
  assign out_valid    = out_valid_r;
  assign out_paged    = out_paged_r;
  assign out_reserved = out_reserved_r;
  assign out_addr     = out_addr_r;
  assign scan_addr    = scan_addr_r;
  assign scan_valid   = scan_valid_r;

  property p_gate;
    @(posedge sys_clk) disable iff (rst)
      !(pci_mem_en && misc_output_reg[vap_pkg::VAP_MISC_RAM_BIT])
      |=> !out_valid;
  endproperty
  a_gate: assert property (p_gate)
    else $error("cycle passed gate");

  property p_paged_addr;
    @(posedge sys_clk) disable iff (rst)
      paged_cycle && tgt_vga |=> out_valid && out_paged
        && out_addr == stolen_memory_base_reg
           + ADDR_W'({$past(page), $past(mem_addr_in[15:2]), 2'b00});
  endproperty
  a_paged_addr: assert property (p_paged_addr)
    else $error("bad paged addr");

  property p_page_bits;
    @(posedge sys_clk) disable iff (rst)
      wr_page ##1 !wr_page |-> page == $past(io_wdata[6:0]);
  endproperty
  a_page_bits: assert property (p_page_bits)
    else $error("page not stored");

  property p_upper_ignored;
    @(posedge sys_clk) disable iff (rst)
      paged_cycle && tgt_vga && $stable(page) && $stable(mem_addr_in)
      && $stable(stolen_memory_base_reg) && $past(paged_cycle && tgt_vga)
      |=> $stable(out_addr);
  endproperty
  a_upper_ignored: assert property (p_upper_ignored)
    else $error("upper bits used");

  property p_reserved;
    @(posedge sys_clk) disable iff (rst)
      paged_cycle && !tgt_vga |=> out_reserved && !out_valid;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved target used");

  property p_legacy;
    @(posedge sys_clk) disable iff (rst)
      honoured && !page_en |=> out_valid && !out_paged
        && out_addr == $past(legacy_addr);
  endproperty
  a_legacy: assert property (p_legacy)
    else $error("legacy path wrong");

  property p_scan;
    @(posedge sys_clk) disable iff (rst)
      scan_page >= vap_pkg::VAP_SCAN_PAGES |=> !scan_valid;
  endproperty
  a_scan: assert property (p_scan)
    else $error("scan beyond four pages");

  property p_scratch;
    @(posedge sys_clk) disable iff (rst)
      wr_scr |=> $stable(map_ctrl_r) && $stable(page_sel_r);
  endproperty
  a_scratch: assert property (p_scratch)
    else $error("scratch side effect");

  property p_reset_off;
    @(posedge sys_clk) rst |=> !page_en;
  endproperty
  a_reset_off: assert property (p_reset_off)
    else $error("enable not reset");

  property p_b_window;
    @(posedge sys_clk) disable iff (rst)
      honoured && page_en && in_win_b && map_a_only
      |=> !out_valid && !out_paged && out_addr == '0;
  endproperty
  a_b_window: assert property (p_b_window)
    else $error("b window passed while paging");

  property p_no_window;
    @(posedge sys_clk) disable iff (rst)
      mem_req && !in_win_a && !in_win_b |=> !out_valid;
  endproperty
  a_no_window: assert property (p_no_window)
    else $error("cycle outside window passed");

  property p_index_wr;
    @(posedge sys_clk) disable iff (rst)
      io_wr && hit_index |=> index_r == $past(io_wdata);
  endproperty
  a_index_wr: assert property (p_index_wr)
    else $error("index not stored");

  // memory cycles must never reach the register file
  property p_mem_no_reg;
    @(posedge sys_clk) disable iff (rst)
      mem_req && !io_wr
      |=> $stable(map_ctrl_r) && $stable(page_sel_r) && $stable(scratch_r);
  endproperty
  a_mem_no_reg: assert property (p_mem_no_reg)
    else $error("memory cycle changed a register");

  property p_scratch_rd;
    @(posedge sys_clk) disable iff (rst)
      io_rd && hit_data && index_r == vap_pkg::VAP_IDX_SCRATCH
      |=> io_rdata == $past(scratch_r);
  endproperty
  a_scratch_rd: assert property (p_scratch_rd)
    else $error("scratch read back wrong");

  property p_scan_addr;
    @(posedge sys_clk) disable iff (rst)
      scan_page < vap_pkg::VAP_SCAN_PAGES |=> scan_valid
        && scan_addr == $past(stolen_memory_base_reg)
           + ADDR_W'({$past(scan_page), 16'h0000});
  endproperty
  a_scan_addr: assert property (p_scan_addr)
    else $error("bad scan address");

  property p_reset_clear;
    @(posedge sys_clk) rst |=> map_ctrl_r == vap_pkg::VAP_RESET_VALUE
      && page_sel_r == vap_pkg::VAP_RESET_VALUE
      && !out_valid && !out_paged && !out_reserved && !scan_valid;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("reset left state behind");

  property p_vga_target;
    @(posedge sys_clk) disable iff (rst)
      paged_cycle && tgt_vga |=> !out_reserved;
  endproperty
  a_vga_target: assert property (p_vga_target)
    else $error("vga target flagged reserved");

  property p_off_target;
    @(posedge sys_clk) disable iff (rst)
      honoured && !page_en && !tgt_vga |=> out_valid && !out_reserved;
  endproperty
  a_off_target: assert property (p_off_target)
    else $error("target used while paging off");
endmodule : vap_paging
`default_nettype wire

/* File: vap_pkg.sv */
// constants for the aperture paging block
package vap_pkg;
  localparam logic [15:0] VAP_IO_INDEX_PORT = 16'h03ce;
  localparam logic [15:0] VAP_IO_DATA_PORT  = 16'h03cf;
  localparam logic [7:0]  VAP_IDX_MAP_CTRL  = 8'h10;
  localparam logic [7:0]  VAP_IDX_PAGE_SEL  = 8'h11;
  localparam logic [7:0]  VAP_IDX_SCRATCH   = 8'h18;
  localparam logic [7:0]  VAP_RESET_VALUE   = 8'h00;
  localparam int          VAP_ENABLE_BIT    = 0;
  localparam int          VAP_TARGET_LSB    = 1;
  localparam int          VAP_PAGE_MSB      = 6;
  localparam logic [1:0]  VAP_TARGET_VGA    = 2'h0;
  localparam logic [1:0]  VAP_MAP_SEL_A0    = 2'h1;
  localparam int          VAP_MAP_SEL_LSB   = 2;
  localparam int          VAP_MISC_RAM_BIT  = 1;
  localparam logic [3:0]  VAP_WIN_A_HI      = 4'ha;
  localparam logic [3:0]  VAP_WIN_B_HI      = 4'hb;
  localparam logic [6:0]  VAP_SCAN_PAGES    = 7'h04;
endpackage : vap_pkg
